// file: core/dsr_consts.svh
// Constants of the drive serial register block: offsets, fields, codes, timing.
// Assumes a single system clock; included by bare name.
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH

`define DSR_CLK_HZ 40000000
`define DSR_BAUD 9600
`define DSR_OVS 16
`define DSR_GAP_BITS 39
`define DSR_FRAME_LEN 8
`define DSR_PARAM_DEPTH 256

`define DSR_FC_READ 8'h03
`define DSR_FC_WRITE 8'h06
`define DSR_EXC_FLAG 8'h80
`define DSR_EX_FUNC 8'h01
`define DSR_EX_ADDR 8'h02
`define DSR_EX_VALUE 8'h03
`define DSR_BCAST 8'h00
`define DSR_SLAVE_DEF 8'h01

`define DSR_CRC_INIT 16'hffff
`define DSR_CRC_POLY 16'ha001

`define DSR_REG_ACCEL 16'h0012
`define DSR_REG_DECEL 16'h0013
`define DSR_REG_PRIM_SPEED 16'h001f
`define DSR_REG_CMD 16'h2000
`define DSR_REG_SETPT 16'h2001
`define DSR_REG_CMD_LAST 16'h2002
`define DSR_REG_FAULT 16'h2100
`define DSR_REG_OUTFREQ 16'h2103
`define DSR_REG_MON_LAST 16'h210f

`define DSR_CMD_RUN 1
`define DSR_CMD_FWD 4
`define DSR_CMD_RAMP_LO 6
`define DSR_CMD_RAMP_HI 7
`define DSR_CMD_SPD_HI 10
`define DSR_CMD_RST 16'h0000
`define DSR_PARAM_RST 16'h0000

`define DSR_FAULT_COUNT 17
`define DSR_FLT_NONE 8'h00
`define DSR_FLT_CONVERTER 8'h01
`define DSR_FLT_POWER_MOD 8'h02
`define DSR_FLT_MEMORY 8'h03
`define DSR_FLT_OVERCURRENT 8'h08
`define DSR_FLT_OVERVOLT 8'h0c
`define DSR_FLT_UNDERVOLT 8'h0d
`define DSR_FLT_GROUND 8'h0e
`define DSR_FLT_DRV_HOT 8'h0f
`define DSR_FLT_MOT_OVL 8'h10
`define DSR_FLT_DRV_OVL 8'h11
`define DSR_FLT_SYS_OVL 8'h12
`define DSR_FLT_EXTERNAL 8'h13
`define DSR_FLT_KEYPAD 8'h14
`define DSR_FLT_THERMAL 8'h16
`define DSR_FLT_MOT_HOT 8'h17
`define DSR_FLT_FEEDBACK 8'h18
`define DSR_FLT_CUR_LIMIT 8'h19

`endif

// file: core/dsr_pkg.sv
// Types shared by the drive serial register block.
// Assumes dsr_consts.svh for the numeric constants.
`default_nettype none
package dsr_pkg;
    typedef enum logic [2:0] {
        dsr_rx_frame,
        dsr_exec,
        dsr_mem_wait,
        dsr_tx_byte,
        dsr_tx_wait
    } dsr_state_t;
    typedef logic [7:0] dsr_byte_t;
    typedef logic [15:0] dsr_word_t;
endpackage : dsr_pkg
`default_nettype wire

// file: core/dsr_mem_if.sv
// Port bundle between the frame engine and the parameter memory.
// Assumes one clock shared by both ends.
`default_nettype none
interface dsr_mem_if #(parameter int AW = 8);
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic we;
    logic [15:0] rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface : dsr_mem_if
`default_nettype wire

// file: core/dsr_param_mem.sv
// Parameter store addressed by function number, registered read data.
// Assumes the controller holds addr one cycle before using rdata.
`default_nettype none
module dsr_param_mem
    import dsr_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk_sys,
    dsr_mem_if.mem port
);
    logic [15:0] store [DEPTH];

    // No reset on the array so it maps onto block RAM
    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        port.rdata <= store[port.addr];
    end
endmodule : dsr_param_mem
`default_nettype wire

// file: core/dsr_serial_regs.sv
// Drive serial register access: RTU slave with read-one and write-one functions.
// Assumes rxd comes asynchronous from a pin, fault and status inputs from the pins of the power stage.
`include "dsr_consts.svh"
`default_nettype none
// Overview of operation
// - Registers DRIVE_COMMAND_WORD to 2002H take writes and answer every read with an exception.
// - Registers FAULT_CODE_MONITOR to 210FH answer reads and answer every write with an exception.
// - While any command-word bit b6 to bA is set, multi-speed requests 1 to 3 from inputs are masked off.
// - Fault codes are 08H overcurrent, 0CH overvoltage, 0DH undervoltage running, 0EH ground fault.
// - Fault codes are 01H converter, 02H power module, 03H memory, 0FH drive overheat, 16H thermal sensor.
// - Fault codes are 10H, 11H, 12H overloads, 13H external, 14H keypad, 17H motor hot, 18H feedback, 19H limit.
// - A write-one frame carries function 06H, a 16-bit address and a 16-bit word, high byte first.
// - Parameters sit at their function number as address, speeds in 0.01 Hz counts.
// - Writing 0002H to DRIVE_COMMAND_WORD sets the run bit.
// - Writing 0010H to DRIVE_COMMAND_WORD selects forward rotation.
// - A write to FREQUENCY_SETPOINT becomes the speed target in 0.01 Hz, overriding the stored primary speed.
// - Accel and decel parameters leave the block as counts of 0.1 s.
// - Command bits b6 and b7 both zero select the primary ramp times.
// - A read uses function 03H with start and count; one register at FAULT_CODE_MONITOR gives the fault code.
// - Register OUTPUT_FREQUENCY_MONITOR returns the output frequency in 0.01 Hz counts.
module dsr_serial_regs
    import dsr_pkg::*;
#(
    parameter logic [7:0] SLAVE_ADDR = `DSR_SLAVE_DEF,
    parameter int BAUD = `DSR_BAUD,
    parameter int PARAM_DEPTH = `DSR_PARAM_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic rxd,
    output logic txd,
    input wire logic [16:0] fault_in,
    input wire logic fault_clear,
    input wire logic [2:0] multi_speed_in,
    input wire logic [15:0] output_freq,
    output logic run_cmd,
    output logic forward_cmd,
    output logic primary_ramp,
    output logic [1:0] ramp_select,
    output logic [2:0] multi_speed_step,
    output logic [15:0] speed_target,
    output logic [15:0] accel_time,
    output logic [15:0] decel_time
);
    localparam int DIV = `DSR_CLK_HZ / (BAUD * `DSR_OVS);
    localparam int GAP = `DSR_GAP_BITS * `DSR_OVS;
    localparam int AW = $clog2(PARAM_DEPTH);

    // Oversampling enable
    logic [15:0] div_cnt;
    logic tick;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else if (div_cnt == 16'(DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end
    assign tick = (div_cnt == 16'(DIV - 1));

    // Pin synchronisers
    logic [1:0] rx_sync;
    logic [16:0] flt_s1, flt_s2;
    logic [2:0] ms_s1, ms_s2;
    logic clr_s1, clr_s2;
    logic rx_s;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_sync <= 2'h3;
            flt_s1 <= '0;
            flt_s2 <= '0;
            ms_s1 <= '0;
            ms_s2 <= '0;
            clr_s1 <= 1'b0;
            clr_s2 <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[0], rxd};
            flt_s1 <= fault_in;
            flt_s2 <= flt_s1;
            ms_s1 <= multi_speed_in;
            ms_s2 <= ms_s1;
            clr_s1 <= fault_clear;
            clr_s2 <= clr_s1;
        end
    end
    assign rx_s = rx_sync[1];

    // Receiver: sample mid-bit at the eighth oversample
    logic rx_busy, rx_valid;
    logic [3:0] rx_cnt, rx_bit;
    logic [7:0] rx_shift;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_busy <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_shift <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (!rx_s) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= '0;
                    rx_bit <= '0;
                end
            end else if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == 4'h7) begin
                    rx_bit <= rx_bit + 4'h1;
                    if (rx_bit == 4'h0 && rx_s) begin
                        rx_busy <= 1'b0;
                    end else if (rx_bit == 4'h9) begin
                        rx_busy <= 1'b0;
                        rx_valid <= rx_s;
                    end else if (rx_bit != 4'h0) begin
                        rx_shift <= {rx_s, rx_shift[7:1]};
                    end
                end
            end
        end
    end

    // Line silence marks the frame end
    logic [15:0] sil_cnt;
    logic gap_hit;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sil_cnt <= '0;
        end else if (rx_busy || !rx_s) begin
            sil_cnt <= '0;
        end else if (tick && sil_cnt != 16'(GAP)) begin
            sil_cnt <= sil_cnt + 16'h0001;
        end
    end
    assign gap_hit = tick && (sil_cnt == 16'(GAP - 1));

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `DSR_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    function automatic logic [7:0] fault_code_of(input int idx);
        case (idx)
            0: return `DSR_FLT_CONVERTER;
            1: return `DSR_FLT_POWER_MOD;
            2: return `DSR_FLT_MEMORY;
            3: return `DSR_FLT_OVERCURRENT;
            4: return `DSR_FLT_OVERVOLT;
            5: return `DSR_FLT_UNDERVOLT;
            6: return `DSR_FLT_GROUND;
            7: return `DSR_FLT_DRV_HOT;
            8: return `DSR_FLT_MOT_OVL;
            9: return `DSR_FLT_DRV_OVL;
            10: return `DSR_FLT_SYS_OVL;
            11: return `DSR_FLT_EXTERNAL;
            12: return `DSR_FLT_KEYPAD;
            13: return `DSR_FLT_THERMAL;
            14: return `DSR_FLT_MOT_HOT;
            15: return `DSR_FLT_FEEDBACK;
            16: return `DSR_FLT_CUR_LIMIT;
            default: return `DSR_FLT_NONE;
        endcase
    endfunction : fault_code_of

    // Lowest index wins when several trips arrive together
    logic [7:0] next_fault;
    always_comb begin
        next_fault = `DSR_FLT_NONE;
        for (int i = `DSR_FAULT_COUNT - 1; i >= 0; i--) begin
            if (flt_s2[i]) begin
                next_fault = fault_code_of(i);
            end
        end
    end

    // First trip is held; a trip still present during the clear reloads it
    logic [7:0] fault_code;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fault_code <= `DSR_FLT_NONE;
        end else if (next_fault != `DSR_FLT_NONE && (fault_code == `DSR_FLT_NONE || clr_s2)) begin
            fault_code <= next_fault;
        end else if (clr_s2) begin
            fault_code <= `DSR_FLT_NONE;
        end
    end

    // Frame capture
    dsr_byte_t frame [`DSR_FRAME_LEN];
    logic [3:0] rx_idx;
    logic [15:0] rx_crc;
    dsr_state_t state;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_idx <= '0;
            rx_crc <= `DSR_CRC_INIT;
            for (int i = 0; i < `DSR_FRAME_LEN; i++) begin
                frame[i] <= 8'h00;
            end
        end else if (state != dsr_rx_frame || gap_hit) begin
            rx_idx <= '0;
            rx_crc <= `DSR_CRC_INIT;
        end else if (rx_valid) begin
            if (rx_idx < 4'(`DSR_FRAME_LEN)) begin
                frame[rx_idx[2:0]] <= rx_shift;
            end
            if (rx_idx != 4'hf) begin
                rx_idx <= rx_idx + 4'h1;
            end
            rx_crc <= crc_step(rx_crc, rx_shift);
        end
    end

    logic frame_ok;
    logic [15:0] req_addr, req_data;
    logic addr_param, addr_cmd, addr_mon, bcast;
    // Residue of zero after the trailing CRC bytes means a good frame
    assign frame_ok = gap_hit && rx_idx == 4'(`DSR_FRAME_LEN) && rx_crc == 16'h0000
                      && (frame[0] == SLAVE_ADDR || frame[0] == `DSR_BCAST);
    assign req_addr = {frame[2], frame[3]};
    assign req_data = {frame[4], frame[5]};
    assign addr_param = req_addr < 16'(PARAM_DEPTH);
    assign addr_cmd = req_addr >= `DSR_REG_CMD && req_addr <= `DSR_REG_CMD_LAST;
    assign addr_mon = req_addr >= `DSR_REG_FAULT && req_addr <= `DSR_REG_MON_LAST;
    assign bcast = frame[0] == `DSR_BCAST;

    dsr_mem_if #(.AW(AW)) mem_bus ();
    dsr_param_mem #(.DEPTH(PARAM_DEPTH), .AW(AW)) u_mem (.clk_sys(clk_sys), .port(mem_bus));
    assign mem_bus.addr = req_addr[AW-1:0];
    assign mem_bus.wdata = req_data;
    assign mem_bus.we = state == dsr_exec && frame[1] == `DSR_FC_WRITE && addr_param;

    // Writable registers
    logic [15:0] cmd_word, setpoint, cmd_spare, prim_speed;
    logic setpoint_valid, do_write;
    assign do_write = state == dsr_exec && frame[1] == `DSR_FC_WRITE;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmd_word <= `DSR_CMD_RST;
            setpoint <= `DSR_PARAM_RST;
            cmd_spare <= `DSR_PARAM_RST;
            setpoint_valid <= 1'b0;
        end else if (do_write && addr_cmd) begin
            if (req_addr == `DSR_REG_CMD) begin
                cmd_word <= req_data;
            end else if (req_addr == `DSR_REG_SETPT) begin
                setpoint <= req_data;
                setpoint_valid <= 1'b1;
            end else begin
                cmd_spare <= req_data;
            end
        end
    end

    // Shadows of the parameters that steer the drive directly
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prim_speed <= `DSR_PARAM_RST;
            accel_time <= `DSR_PARAM_RST;
            decel_time <= `DSR_PARAM_RST;
        end else if (do_write && addr_param) begin
            if (req_addr == `DSR_REG_PRIM_SPEED) begin
                prim_speed <= req_data;
            end else if (req_addr == `DSR_REG_ACCEL) begin
                accel_time <= req_data;
            end else if (req_addr == `DSR_REG_DECEL) begin
                decel_time <= req_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_cmd <= 1'b0;
            forward_cmd <= 1'b0;
            ramp_select <= 2'h0;
            primary_ramp <= 1'b1;
            multi_speed_step <= 3'h0;
            speed_target <= `DSR_PARAM_RST;
        end else begin
            run_cmd <= cmd_word[`DSR_CMD_RUN];
            forward_cmd <= cmd_word[`DSR_CMD_FWD];
            ramp_select <= cmd_word[`DSR_CMD_RAMP_HI:`DSR_CMD_RAMP_LO];
            primary_ramp <= cmd_word[`DSR_CMD_RAMP_HI:`DSR_CMD_RAMP_LO] == 2'h0;
            multi_speed_step <= (|cmd_word[`DSR_CMD_SPD_HI:`DSR_CMD_RAMP_LO]) ? 3'h0 : ms_s2;
            speed_target <= setpoint_valid ? setpoint : prim_speed;
        end
    end

    // Reply assembly and transmit
    dsr_byte_t reply [6];
    logic [2:0] reply_len, tx_idx;
    logic [15:0] tx_crc;
    logic tx_busy, tx_go;
    logic [3:0] tx_cnt, tx_bit;
    logic [9:0] tx_shift;
    dsr_byte_t tx_byte;

    always_comb begin
        if (tx_idx < reply_len) begin
            tx_byte = reply[tx_idx];
        end else if (tx_idx == reply_len) begin
            tx_byte = tx_crc[7:0];
        end else begin
            tx_byte = tx_crc[15:8];
        end
    end
    assign tx_go = state == dsr_tx_byte && !tx_busy;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= dsr_rx_frame;
            reply_len <= '0;
            tx_idx <= '0;
            tx_crc <= `DSR_CRC_INIT;
            for (int i = 0; i < 6; i++) begin
                reply[i] <= 8'h00;
            end
        end else begin
            case (state)
                dsr_rx_frame: begin
                    tx_idx <= '0;
                    tx_crc <= `DSR_CRC_INIT;
                    if (frame_ok) begin
                        state <= dsr_exec;
                    end
                end
                dsr_exec: begin
                    reply[0] <= SLAVE_ADDR;
                    reply[1] <= frame[1] | `DSR_EXC_FLAG;
                    reply_len <= 3'h3;
                    state <= bcast ? dsr_rx_frame : dsr_tx_byte;
                    if (frame[1] == `DSR_FC_WRITE) begin
                        if (addr_param || addr_cmd) begin
                            for (int i = 1; i < 6; i++) begin
                                reply[i] <= frame[i];
                            end
                            reply_len <= 3'h6;
                        end else begin
                            reply[2] <= `DSR_EX_ADDR;
                        end
                    end else if (frame[1] == `DSR_FC_READ && !bcast) begin
                        if (req_data != 16'h0001) begin
                            reply[2] <= `DSR_EX_VALUE;
                        end else if (addr_param || addr_mon) begin
                            reply[1] <= `DSR_FC_READ;
                            reply[2] <= 8'h02;
                            reply_len <= 3'h5;
                            if (addr_param) begin
                                state <= dsr_mem_wait;
                            end else if (req_addr == `DSR_REG_FAULT) begin
                                reply[3] <= 8'h00;
                                reply[4] <= fault_code;
                            end else if (req_addr == `DSR_REG_OUTFREQ) begin
                                reply[3] <= output_freq[15:8];
                                reply[4] <= output_freq[7:0];
                            end else begin
                                reply[3] <= 8'h00;
                                reply[4] <= 8'h00;
                            end
                        end else begin
                            reply[2] <= `DSR_EX_ADDR;
                        end
                    end else begin
                        reply[2] <= `DSR_EX_FUNC;
                    end
                end
                dsr_mem_wait: begin
                    reply[3] <= mem_bus.rdata[15:8];
                    reply[4] <= mem_bus.rdata[7:0];
                    state <= dsr_tx_byte;
                end
                dsr_tx_byte: begin
                    if (tx_go) begin
                        if (tx_idx < reply_len) begin
                            tx_crc <= crc_step(tx_crc, tx_byte);
                        end
                        state <= dsr_tx_wait;
                    end
                end
                dsr_tx_wait: begin
                    if (!tx_busy) begin
                        tx_idx <= tx_idx + 3'h1;
                        state <= (tx_idx == reply_len + 3'h1) ? dsr_rx_frame : dsr_tx_byte;
                    end
                end
                default: state <= dsr_rx_frame;
            endcase
        end
    end

    // Transmitter: idle line is held high by the all-ones shifter
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_busy <= 1'b0;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_shift <= 10'h3ff;
        end else if (tx_go) begin
            tx_busy <= 1'b1;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_shift <= {1'b1, tx_byte, 1'b0};
        end else if (tx_busy && tick) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == 4'hf) begin
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bit <= tx_bit + 4'h1;
                if (tx_bit == 4'h9) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end
    assign txd = tx_shift[0];
endmodule : dsr_serial_regs
`default_nettype wire

// file: test/dsr_serial_regs_monitor.sv
// Checker for the drive serial register block, watching top-level ports only.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none
module dsr_serial_regs_monitor (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic txd,
    input wire logic run_cmd,
    input wire logic forward_cmd,
    input wire logic primary_ramp,
    input wire logic [1:0] ramp_select,
    input wire logic [2:0] multi_speed_step,
    input wire logic [15:0] speed_target
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_PRIMARY: assert property (primary_ramp == (ramp_select == 2'h0))
        else $error("primary ramp flag disagrees with ramp select");
    AST_MASK: assert property (ramp_select != 2'h0 && $stable(ramp_select) |-> multi_speed_step == 3'h0)
        else $error("multi speed step not masked");
    AST_START_BIT: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    AST_RUN_IDLE: assert property ($changed(run_cmd) |-> $past(txd))
        else $error("run changed during a reply");
    AST_RUN_REPLY: assert property ($rose(run_cmd) |-> ##[0:4] !txd)
        else $error("no reply after run write");
    AST_RESET: assert property ($rose(rstn) |-> txd && primary_ramp && !run_cmd && !forward_cmd)
        else $error("wrong values out of reset");
    AST_FWD_IDLE: assert property ($changed(forward_cmd) || $changed(ramp_select) |-> $past(txd))
        else $error("command bits changed during a reply");
    AST_SPEED_IDLE: assert property ($changed(speed_target) |-> $past(txd))
        else $error("speed target changed during a reply");
endmodule : dsr_serial_regs_monitor
bind dsr_serial_regs dsr_serial_regs_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .txd(txd),
    .run_cmd(run_cmd), .forward_cmd(forward_cmd), .primary_ramp(primary_ramp), .ramp_select(ramp_select),
    .multi_speed_step(multi_speed_step), .speed_target(speed_target));
`default_nettype wire

// file: test/dsr_host_model.sv
// Host master model: sends RTU request frames on rxd and collects reply bytes from txd.
// Assumes one bit time of 16 clocks; all line changes at the falling clock edge.
`default_nettype none
module dsr_host_model (
    input wire logic clk_sys,
    output logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    function automatic logic [15:0] crc16(input logic [47:0] m);
        logic [15:0] c = 16'hffff;
        for (int j = 0; j < 6; j++) begin
            c ^= {8'h00, m[47-8*j -: 8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (16) @(negedge clk_sys);
        end
    endtask : put_byte
    // A set bad flag corrupts the CRC so the frame must be dropped
    task automatic send(input logic [47:0] m, input logic bad);
        logic [15:0] c = crc16(m) ^ {15'h0, bad};
        @(negedge clk_sys);
        for (int j = 0; j < 6; j++) put_byte(m[47-8*j -: 8]);
        put_byte(c[7:0]);
        put_byte(c[15:8]);
    endtask : send
    task automatic get_byte(output logic [7:0] b, output logic ok);
        int t = 0;
        ok = 1'b0;
        b = 8'h00;
        while (txd !== 1'b0 && t < 1000) begin
            @(negedge clk_sys);
            t++;
        end
        if (t < 1000) begin
            ok = 1'b1;
            repeat (8) @(negedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(negedge clk_sys);
                b[i] = txd;
            end
            repeat (16) @(negedge clk_sys);
        end
    endtask : get_byte
endmodule : dsr_host_model
`default_nettype wire

// file: test/tb_top.sv
// Testbench for the drive serial register block: request frames with expected replies and outputs.
// Assumes the host model above and a fast baud setting of one clock per oversample tick.
`default_nettype none
module tb_top;
    import dsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rstn = 1'b0, rxd, txd, fault_clear = 1'b0, ok;
    logic run_cmd, forward_cmd, primary_ramp;
    logic [1:0] ramp_select;
    logic [2:0] multi_speed_in = 3'h3, multi_speed_step;
    logic [16:0] fault_in = 17'h0;
    dsr_word_t output_freq = 16'h0fe1, speed_target, accel_time, decel_time;
    logic [7:0] rsp [8];
    int num_errors = 0, cmp_count = 0;
    localparam logic [7:0] FC [17] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
        8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19};
    dsr_serial_regs #(.BAUD(2500000)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .rxd(rxd), .txd(txd),
        .fault_in(fault_in), .fault_clear(fault_clear), .multi_speed_in(multi_speed_in),
        .output_freq(output_freq), .run_cmd(run_cmd), .forward_cmd(forward_cmd), .primary_ramp(primary_ramp),
        .ramp_select(ramp_select), .multi_speed_step(multi_speed_step), .speed_target(speed_target),
        .accel_time(accel_time), .decel_time(decel_time));
    dsr_host_model u_host (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic wrap_up;
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Sends one request, takes n reply bytes, then keeps the line silent for the frame gap
    task automatic xfer(input logic [47:0] m, input int n);
        u_host.send(m, 1'b0);
        for (int i = 0; i < n; i++) u_host.get_byte(rsp[i], ok);
        repeat (640) @(negedge clk_sys);
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        xfer({8'h01, 8'h06, a, d}, 8);
        chk({rsp[0], rsp[1], rsp[2], rsp[3], rsp[4], rsp[5]}, {8'h01, 8'h06, a, d});
        chk({rsp[7], rsp[6]}, u_host.crc16({rsp[0], rsp[1], rsp[2], rsp[3], rsp[4], rsp[5]}));
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        xfer({8'h01, 8'h03, a, 16'h0001}, 7);
        chk({rsp[0], rsp[1], rsp[2], rsp[3], rsp[4]}, {8'h01, 8'h03, 8'h02, exp});
    endtask : rd
    // Broadcast write: executed without a reply, so only silence follows
    task automatic bc(input logic [15:0] a, input logic [15:0] d);
        u_host.send({8'h00, 8'h06, a, d}, 1'b0);
        repeat (1300) @(negedge clk_sys);
    endtask : bc
    initial begin
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (700) @(negedge clk_sys);
        wr(16'h2000, 16'h0002);
        chk(run_cmd, 1'b1);
        u_host.send({8'h01, 8'h06, 16'h2000, 16'h0000}, 1'b1);
        u_host.get_byte(rsp[0], ok);
        chk({ok, run_cmd}, 2'b01);
        wr(16'h2000, 16'h0010);
        chk({forward_cmd, run_cmd}, 2'b10);
        wr(16'h2000, 16'h00c0);
        chk({primary_ramp, ramp_select, multi_speed_step}, 6'b0_11_000);
        bc(16'h2000, 16'h0400);
        chk({primary_ramp, ramp_select, multi_speed_step}, 6'b1_00_000);
        wr(16'h2000, 16'h0000);
        chk({primary_ramp, ramp_select, multi_speed_step}, 6'b1_00_011);
        wr(16'h001f, 16'h0bb8);
        chk(speed_target, 16'h0bb8);
        rd(16'h001f, 16'h0bb8);
        wr(16'h2001, 16'h0bbd);
        chk(speed_target, 16'h0bbd);
        wr(16'h0012, 16'h000f);
        chk(accel_time, 16'h000f);
        bc(16'h0013, 16'h000f);
        chk(decel_time, 16'h000f);
        xfer({8'h01, 8'h03, 16'h2000, 16'h0001}, 5);
        chk({rsp[1], rsp[2]}, 16'h8302);
        xfer({8'h01, 8'h06, 16'h2100, 16'h0005}, 5);
        chk({rsp[1], rsp[2]}, 16'h8602);
        chk(speed_target, 16'h0bbd);
        rd(16'h2103, 16'h0fe1);
        for (int i = 0; i < 17; i++) begin
            fault_in = 17'h1 << i;
            repeat (8) @(negedge clk_sys);
            rd(16'h2100, {8'h00, FC[i]});
            fault_in = 17'h0;
            fault_clear = 1'b1;
            repeat (6) @(negedge clk_sys);
            fault_clear = 1'b0;
        end
        wrap_up();
    end
    initial begin
        repeat (150000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
